// >>> verilog/sbc_regs.vh
/*
  Constants for the system bus command host: its own APB register map, the
  cycle command encodings and the device mode register layout.
  Assumes inclusion by bare name from the host design file.
*/
// Function
// [RL1] Agent asserts bus request; processor goes slave
// [RL2] Keep data-valid input high during bypass transfer
// [RL3] Release request after transfer; processor regains mastership
// [RL4] Extra drivers use their own valid lines
// [RL5] Command top bit: 0 address, 1 data
// [RL6] External commands carry defined values in every bit
// [RL7] Address bit3 read/write, bit2 single/block
// [RL8] Only single-data writes issued toward processor
// [RL9] Block size: 1 four words, 2 eight
// [RL10] Single size: byte, halfword, tribyte, word
// [RL11] Processor data id: bit3 last, bit1 0, bit0 1
// [RL12] External data id: bit3 last, bit2 response
// [RL13] External id bit1 error flag, bit0 driven 1
// [RL14] Processor drives full 32-bit address
// [RL15] Single addresses aligned to element size
// [RL16] Block read data: addressed word first, sequential
// [RL17] Block write addresses block aligned
// [RL18] Mode register accessed only as full word
// [RL19] Bits 19:4 timeout reload 0xffff, bit3 enable
// [RL20] Bit1 selects single eight-word burst write
// [RL21] Bit0 selects four words per 12 cycles
// [RL22] Layout valid with bus mode strap low
// [RL23] Timeout counts while waiting, error at zero
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// ---------------------------------------------------------------
// Host registers over APB
// ---------------------------------------------------------------
`define SBC_CTRL_OFS      12'h000
`define SBC_ADDR_OFS      12'h004
`define SBC_WDATA_OFS     12'h008
`define SBC_STAT_OFS      12'h00c
`define SBC_RDATA_OFS     12'h010
`define SBC_RCMD_OFS      12'h014
`define SBC_CTRL_GO_BIT   0
`define SBC_CTRL_BYP_BIT  1
`define SBC_CTRL_SZ_LSB   2
`define SBC_STAT_BUSY_BIT 0
`define SBC_STAT_SLV_BIT  1
`define SBC_STAT_RX_BIT   2
`define SBC_STAT_ILL_BIT  3

// ---------------------------------------------------------------
// Cycle command encodings
// ---------------------------------------------------------------
`define SBC_CMD_DATA_BIT  4
`define SBC_CMD_WR_BIT    3
`define SBC_CMD_BLK_BIT   2
`define SBC_ID_LAST_BIT   3
`define SBC_ID_RESP_BIT   2
`define SBC_ID_ERR_BIT    1
`define SBC_ID_CHK_BIT    0
`define SBC_SZ_BYTE       2'h0
`define SBC_SZ_HALF       2'h1
`define SBC_SZ_TRI        2'h2
`define SBC_SZ_WORD       2'h3
`define SBC_BLK_FOUR      2'h1
`define SBC_BLK_EIGHT     2'h2

// ---------------------------------------------------------------
// Device mode register (device side map)
// ---------------------------------------------------------------
`define SBC_MODE_ADDR     36'hfff100000
`define SBC_MODE_TOV_LSB  4
`define SBC_MODE_TOV_MSB  19
`define SBC_MODE_TOE_BIT  3
`define SBC_MODE_B8_BIT   1
`define SBC_MODE_WBR_BIT  0
`define SBC_MODE_RESET    32'h000ffff0

`endif

// >>> verilog/sbc_host.v
/*
  External-agent host for the processor system bus. Software on APB queues
  single-data writes toward the processor and can claim the bus for a
  bypass transfer; data cycles from the processor are captured.
  Assumes the processor pins are synchronous to core_clk and that the
  bench resolves the shared address/data and command wires from the enables.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"

module sbc_host (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [31:0] sysAddrDataBusIn,
  output reg  [31:0] sysAddrDataBusOut,
  output reg         sysAddrDataBusOe,
  input  wire [4:0]  cycleCommandBusIn,
  output reg  [4:0]  cycleCommandBusOut,
  output reg         cycleCommandBusOe,
  output reg         externalBusRequest_n,
  output reg         externalDataValid_n,
  input  wire        processorOwnsBus_n,
  input  wire        processorDataValid_n
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  // One-hot; release waits until the processor has taken the bus back
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_REQ  = 5'h02;
  localparam [4:0] ST_ADR  = 5'h04;
  localparam [4:0] ST_DAT  = 5'h08;
  localparam [4:0] ST_REL  = 5'h10;

  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg [31:0] addr_ff;
  reg [31:0] wdata_ff;
  reg [1:0]  size_ff;
  reg        bypass_ff;
  reg        go_ff;
  reg        rxFlag_ff;
  reg        illegal_ff;
  reg [31:0] rdata_ff;
  reg [4:0]  rcmd_ff;
  reg        nxt_busRequest_n;
  reg        nxt_dataValid_n;
  reg        nxt_drive;
  reg [31:0] nxt_adOut;
  reg [4:0]  nxt_cmdOut;

  wire apbWr   = psel && penable && pwrite;
  wire apbRd   = psel && penable && !pwrite;
  wire fullWd  = (pstrb == 4'hf); // [RL18]
  wire rxCycle = !processorDataValid_n && cycleCommandBusIn[`SBC_CMD_DATA_BIT]; // [RL11]
  wire slave   = processorOwnsBus_n;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Misaligned halfword and word addresses are refused rather than sent to the device; byte and tribyte pass unchecked
  function aligned;
    input [1:0] sz;
    input [1:0] lo;
    begin
      case (sz)
        `SBC_SZ_WORD: aligned = (lo == 2'h0);
        `SBC_SZ_HALF: aligned = (lo[0] == 1'b0);
        default:      aligned = 1'b1;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // APB register writes
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff    <= 32'h0;
      wdata_ff   <= 32'h0;
      size_ff    <= 2'h0;
      bypass_ff  <= 1'b0;
      go_ff      <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      if (state_ff == ST_ADR) begin
        go_ff <= 1'b0;
      end
      if (apbWr && fullWd) begin
        if (paddr == `SBC_ADDR_OFS) begin
          addr_ff <= pwdata;
        end else if (paddr == `SBC_WDATA_OFS) begin
          wdata_ff <= pwdata;
        end else if (paddr == `SBC_CTRL_OFS) begin
          bypass_ff <= pwdata[`SBC_CTRL_BYP_BIT];
          if (pwdata[`SBC_CTRL_GO_BIT] && !go_ff) begin
            if (aligned(pwdata[`SBC_CTRL_SZ_LSB+1:`SBC_CTRL_SZ_LSB], addr_ff[1:0])) begin // [RL15]
              size_ff <= pwdata[`SBC_CTRL_SZ_LSB+1:`SBC_CTRL_SZ_LSB];
              go_ff   <= 1'b1;
            end else begin
              illegal_ff <= 1'b1;
            end
          end
        end else if (paddr == `SBC_STAT_OFS) begin
          if (pwdata[`SBC_STAT_ILL_BIT]) begin
            illegal_ff <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture of processor data cycles
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxFlag_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rcmd_ff   <= 5'h0;
    end else begin
      // One word per data cycle; word order is this agent's duty, never reordered here [RL16]
      if (rxCycle) begin
        rdata_ff  <= sysAddrDataBusIn;
        rcmd_ff   <= cycleCommandBusIn;
        rxFlag_ff <= 1'b1;
      end else if (apbWr && fullWd && paddr == `SBC_STAT_OFS && pwdata[`SBC_STAT_RX_BIT]) begin
        rxFlag_ff <= 1'b0; // Arrival wins over the clear
      end
    end
  end

  // ---------------------------------------------------------------
  // APB reads
  // ---------------------------------------------------------------
  // Data is picked in the setup cycle and held, so the access phase never waits
  wire        busy     = (state_ff != ST_IDLE);
  wire [31:0] ctrlView = {28'h0, size_ff, bypass_ff, go_ff};
  wire [31:0] statView = {28'h0, illegal_ff, rxFlag_ff, slave, busy};
  wire [31:0] rcmdView = {27'h0, rcmd_ff};
  reg  [31:0] nxt_prdata;

  always @* begin
    if (paddr == `SBC_CTRL_OFS) begin
      nxt_prdata = ctrlView;
    end else if (paddr == `SBC_ADDR_OFS) begin
      nxt_prdata = addr_ff;
    end else if (paddr == `SBC_WDATA_OFS) begin
      nxt_prdata = wdata_ff;
    end else if (paddr == `SBC_STAT_OFS) begin
      nxt_prdata = statView;
    end else if (paddr == `SBC_RDATA_OFS) begin
      nxt_prdata = rdata_ff;
    end else if (paddr == `SBC_RCMD_OFS) begin
      nxt_prdata = rcmdView;
    end else begin
      nxt_prdata = 32'h0;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go_ff || bypass_ff) begin
          nxt_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (slave) begin // [RL1]
          if (go_ff)
            nxt_state = ST_ADR;
          else if (!bypass_ff)
            nxt_state = ST_REL;
        end
      end
      ST_ADR: begin
        nxt_state = ST_DAT;
      end
      ST_DAT: begin
        nxt_state = bypass_ff ? ST_REQ : ST_REL;
      end
      ST_REL: begin
        if (!slave) begin // [RL3]
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff             <= ST_IDLE;
      externalBusRequest_n <= 1'b1;
      externalDataValid_n  <= 1'b1;
      sysAddrDataBusOut    <= 32'h0;
      sysAddrDataBusOe     <= 1'b0;
      cycleCommandBusOut   <= 5'h0;
      cycleCommandBusOe    <= 1'b0;
    end else begin
      state_ff             <= nxt_state;
      externalBusRequest_n <= nxt_busRequest_n; // [RL1] [RL3]
      externalDataValid_n  <= nxt_dataValid_n;
      sysAddrDataBusOe     <= nxt_drive;
      cycleCommandBusOe    <= nxt_drive;
      sysAddrDataBusOut    <= nxt_adOut;
      cycleCommandBusOut   <= nxt_cmdOut;
    end
  end

  // ---------------------------------------------------------------
  // Pin decode for the coming cycle
  // ---------------------------------------------------------------
  // Decoded from the next state so every pin leaves a flop and the
  // shared wires never see a glitch from the sequencer decode
  always @* begin
    nxt_busRequest_n = 1'b1;
    nxt_dataValid_n  = 1'b1;
    nxt_drive        = 1'b0;
    nxt_adOut        = sysAddrDataBusOut;
    nxt_cmdOut       = cycleCommandBusOut;
    case (nxt_state)
      ST_REQ: begin
        // Held through a bypass; valid stays high for foreign traffic [RL2] [RL4]
        nxt_busRequest_n = 1'b0; // [RL1]
      end
      ST_ADR: begin
        nxt_busRequest_n = 1'b0;
        nxt_dataValid_n  = 1'b0;
        nxt_drive        = 1'b1;
        nxt_adOut        = addr_ff;
        // Single write only; block sizes never go out [RL5] [RL6] [RL7] [RL8] [RL9] [RL10]
        nxt_cmdOut       = {1'b0, 1'b1, 1'b0, size_ff};
      end
      ST_DAT: begin
        nxt_busRequest_n = 1'b0;
        nxt_dataValid_n  = 1'b0;
        nxt_drive        = 1'b1;
        nxt_adOut        = wdata_ff;
        // Not last, response, error free, checking off [RL12] [RL13]
        nxt_cmdOut       = {1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      end
      default: begin
        // Idle and release drop the request so the processor regains the bus [RL3]
        nxt_busRequest_n = 1'b1;
      end
    endcase
  end

endmodule // sbc_host
`default_nettype wire

// >>> sim/sbc_host_assertions.sv
/* Checker on the sbc_host ports: link framing, ownership, alignment, APB answer.
   Assumes one core_clk domain and asynchronous rst_b. */
`timescale 1ns/1ps
`default_nettype none
module sbc_host_assertions (
  input wire        core_clk,
  input wire        rst_b,
  input wire        psel,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] sysAddrDataBusOut,
  input wire        sysAddrDataBusOe,
  input wire [4:0]  cycleCommandBusOut,
  input wire        cycleCommandBusOe,
  input wire        externalBusRequest_n,
  input wire        externalDataValid_n,
  input wire        processorOwnsBus_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence sAddr;
    sysAddrDataBusOe && !externalDataValid_n && !cycleCommandBusOut[4];
  endsequence
  sequence sData;
    sysAddrDataBusOe && !externalDataValid_n && cycleCommandBusOut[4];
  endsequence
  a_addr_data: assert property (sAddr |=> sData) else $error("no data after address");
  a_single_write: assert property (sAddr |-> cycleCommandBusOut[3:2] == 2'h2) else $error("bad command");
  a_data_ident: assert property (sData |-> cycleCommandBusOut[3:0] == 4'h5) else $error("bad data id");
  a_data_release: assert property (sData |=> !sysAddrDataBusOe && externalDataValid_n) else $error("held");
  a_drive_slave: assert property (sysAddrDataBusOe |-> !externalBusRequest_n && $past(processorOwnsBus_n))
    else $error("drove while processor master");
  a_valid_own: assert property (!externalDataValid_n |-> sysAddrDataBusOe && cycleCommandBusOe)
    else $error("valid without drive");
  a_word_align: assert property (sAddr ##0 cycleCommandBusOut[1:0] == 2'h3 |-> sysAddrDataBusOut[1:0] == 2'h0)
    else $error("word misaligned");
  a_half_align: assert property (sAddr ##0 cycleCommandBusOut[1:0] == 2'h1 |-> !sysAddrDataBusOut[0])
    else $error("half misaligned");
  a_apb_answer: assert property (psel |-> pready && !pslverr) else $error("apb answer");
endmodule // sbc_host_assertions
bind sbc_host sbc_host_assertions sbc_host_assertions_i (.core_clk, .rst_b, .psel, .pready, .pslverr,
  .sysAddrDataBusOut, .sysAddrDataBusOe, .cycleCommandBusOut, .cycleCommandBusOe, .externalBusRequest_n,
  .externalDataValid_n, .processorOwnsBus_n);
`default_nettype wire

// >>> sim/sbc_proc_model.sv
/* Processor-side model: bus arbitration, data cycles, mode register.
   Assumes the bench resolves the shared wires from the drive flags. */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_proc_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        reqN,
  input  wire logic [3:0]  lag,
  input  wire logic        send,
  input  wire logic [31:0] sendData,
  input  wire logic [31:0] adIn,
  input  wire logic [4:0]  cmdIn,
  input  wire logic        hostValidN,
  output logic             ownsN,
  output logic             validN,
  output logic [31:0]      adOut,
  output logic [4:0]       cmdOut,
  output logic             drv,
  output logic [31:0]      gotAddr,
  output logic [31:0]      gotData,
  output logic [4:0]       gotCmd,
  output logic [31:0]      modeReg
);
  logic [3:0] waitCnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {ownsN, drv, waitCnt, gotAddr, gotData, gotCmd, adOut, cmdOut} <= '0;
      validN <= 1'h1;
      modeReg <= `SBC_MODE_RESET;
    end else begin
      // Lag gives a slow grant; saturating so a long bypass never drops it
      waitCnt <= reqN ? 4'h0 : waitCnt + {3'h0, waitCnt != 4'hf};
      ownsN <= !reqN && waitCnt >= lag;
      drv <= send && !ownsN;
      validN <= !(send && !ownsN);
      adOut <= sendData;
      // Only single words are sent, so block alignment and the read time-out never arise
      cmdOut <= 5'h11;
      if (!hostValidN && !cmdIn[4]) {gotAddr, gotCmd} <= {adIn, cmdIn};
      if (!hostValidN && cmdIn[4]) gotData <= adIn;
      if (!hostValidN && cmdIn[4] && gotAddr == 32'(`SBC_MODE_ADDR) && gotCmd[1:0] == 2'h3)
        modeReg <= adIn & 32'h000ffffb;
    end
  end
endmodule // sbc_proc_model
`default_nettype wire

// >>> sim/sbc_host_test.sv
/* Self-checking bench for sbc_host with APB master tasks and processor model.
   Assumes sbc_regs.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_host_test;
  logic core_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, send = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, sendData = 32'h0, rd;
  logic [3:0]  pstrb = 4'h0, lag = 4'h0;
  int          err_count = 0, cmp_count = 0;
  wire         pready, pslverr, hOe, cOe, reqN, hValidN, ownsN, pValidN, drv;
  wire [31:0]  prdata, hOut, pOut, adBus, gotAddr, gotData, modeReg;
  wire [4:0]   hCmd, pCmd, cmdBus, gotCmd;
  // Released wires show the inverse of the host's last drive so stale data never looks valid
  assign adBus = hOe ? hOut : drv ? pOut : ~hOut;
  assign cmdBus = cOe ? hCmd : drv ? pCmd : ~hCmd;
  always #5 core_clk = ~core_clk;
  sbc_host sbc_host_i (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .sysAddrDataBusIn(adBus), .sysAddrDataBusOut(hOut), .sysAddrDataBusOe(hOe),
    .cycleCommandBusIn(cmdBus), .cycleCommandBusOut(hCmd), .cycleCommandBusOe(cOe),
    .externalBusRequest_n(reqN), .externalDataValid_n(hValidN), .processorOwnsBus_n(ownsN),
    .processorDataValid_n(pValidN));
  sbc_proc_model sbc_proc_model_i (.clk(core_clk), .rst_b, .reqN, .lag, .send, .sendData, .adIn(adBus),
    .cmdIn(cmdBus), .hostValidN(hValidN), .ownsN, .validN(pValidN), .adOut(pOut), .cmdOut(pCmd), .drv,
    .gotAddr, .gotData, .gotCmd, .modeReg);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    {psel, penable} <= 2'h0;
    if (n >= 20) begin err_count++; print_verdict; end
  endtask
  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin apb(1'h0, `SBC_STAT_OFS, 32'h0, 4'h0); n++; end while (rd[b] !== v && n < 40);
    if (n >= 40) begin err_count++; print_verdict; end
  endtask
  task go(input logic [31:0] a, input logic [1:0] sz, input logic [3:0] s);
    apb(1'h1, `SBC_ADDR_OFS, a, 4'hf);
    apb(1'h1, `SBC_WDATA_OFS, a ^ 32'h00012340, 4'hf);
    apb(1'h1, `SBC_CTRL_OFS, {28'h0, sz, 2'h1}, s);
  endtask
  task sizes;
    logic [31:0] a [4] = '{32'h201, 32'h202, 32'h203, 32'(`SBC_MODE_ADDR)};
    for (int i = 0; i < 4; i++) begin
      go(a[i], i[1:0], 4'hf);
      poll(`SBC_STAT_BUSY_BIT, 1'h0);
      chk(gotAddr, a[i]);
      chk(gotData, a[i] ^ 32'h00012340);
      chk(gotCmd, {3'h2, i[1:0]});
    end
    chk(modeReg, (32'h00012340 ^ 32'(`SBC_MODE_ADDR)) & 32'h000ffffb);
  endtask
  task refusals;
    go(32'h300, 2'h3, 4'h1);
    repeat (20) @(posedge core_clk);
    chk(gotAddr, 32'(`SBC_MODE_ADDR));
    go(32'h301, 2'h1, 4'hf);
    poll(`SBC_STAT_ILL_BIT, 1'h1);
    chk(gotAddr, 32'(`SBC_MODE_ADDR));
    apb(1'h1, `SBC_STAT_OFS, 32'h8, 4'hf);
    poll(`SBC_STAT_ILL_BIT, 1'h0);
  endtask
  task bypass;
    lag <= 4'h5;
    apb(1'h1, `SBC_CTRL_OFS, 32'h2, 4'hf);
    poll(`SBC_STAT_SLV_BIT, 1'h1);
    chk({reqN, ownsN, hValidN}, 3'h3);
    apb(1'h1, `SBC_CTRL_OFS, 32'h0, 4'hf);
    poll(`SBC_STAT_SLV_BIT, 1'h0);
    chk({reqN, ownsN}, 2'h2);
    lag <= 4'h0;
  endtask
  task capture;
    {send, sendData} <= {1'h1, 32'h13579bdf};
    @(posedge core_clk);
    send <= 1'h0;
    poll(`SBC_STAT_RX_BIT, 1'h1);
    apb(1'h0, `SBC_RDATA_OFS, 32'h0, 4'h0);
    chk(rd, 32'h13579bdf);
    apb(1'h0, `SBC_RCMD_OFS, 32'h0, 4'h0);
    chk(rd, 32'h11);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'h1;
    apb(1'h0, `SBC_STAT_OFS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h020, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(modeReg, `SBC_MODE_RESET);
    sizes;
    refusals;
    bypass;
    capture;
    print_verdict;
  end
endmodule // sbc_host_test
`default_nettype wire
